/* common/cff_pkg.sv */
// Package with register map, field positions and link constants for the fault and flag bank.
package cff_pkg;

	// ********************************************************
	// Register map.
	// ********************************************************
	localparam logic [7:0] CFF_ADDR_FAULT_A = 8'h20;
	localparam logic [7:0] CFF_ADDR_FAULT_B = 8'h21;
	localparam logic [7:0] CFF_ADDR_FLAGS_A = 8'h22;
	localparam logic [7:0] CFF_RESET_VALUE  = 8'h00;
	localparam logic [7:0] CFF_UNMAPPED_VAL = 8'h00;

	// ********************************************************
	// Field positions in fault_status_b.
	// ********************************************************
	localparam int CFF_FB_SYS_SHORT = 7;
	localparam int CFF_FB_SYS_OVP   = 6;
	localparam int CFF_FB_REV_OVP   = 5;
	localparam int CFF_FB_REV_UVP   = 4;
	localparam int CFF_FB_OVERTEMP  = 2;

	// ********************************************************
	// Field positions in event_flags_a.
	// ********************************************************
	localparam int CFF_FL_ICUR      = 7;
	localparam int CFF_FL_IVOLT     = 6;
	localparam int CFF_FL_WDOG      = 5;
	localparam int CFF_FL_WEAK      = 4;
	localparam int CFF_FL_PGOOD     = 3;
	localparam int CFF_FL_IN2       = 2;
	localparam int CFF_FL_IN1       = 1;
	localparam int CFF_FL_BUS       = 0;
	// Flags at and above this bit latch on rising edges, the rest on any change.
	localparam int CFF_FL_RISE_LOW  = 4;

	// ********************************************************
	// Synchroniser layout and serial link constants.
	// ********************************************************
	localparam int CFF_SYNC_W       = 23;
	localparam int CFF_SYNC_FA_LSB  = 0;
	localparam int CFF_SYNC_FB_LSB  = 8;
	localparam int CFF_SYNC_FL_LSB  = 13;
	localparam int CFF_SYNC_SCL     = 21;
	localparam int CFF_SYNC_SDA     = 22;
	// Target address on the serial bus; the value is arbitrary.
	localparam logic [6:0] CFF_DEV_ADDR = 7'h5a;
	localparam logic [3:0] CFF_BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		CFF_ST_IDLE     = 3'b000,
		CFF_ST_ADDR     = 3'b001,
		CFF_ST_ADDR_ACK = 3'b010,
		CFF_ST_PTR      = 3'b011,
		CFF_ST_PTR_ACK  = 3'b100,
		CFF_ST_WDATA    = 3'b101,
		CFF_ST_TX       = 3'b110,
		CFF_ST_TX_ACK   = 3'b111
	} cff_state_t;

endpackage : cff_pkg

/* hw/cff_sync.sv */
// Two-flop synchroniser bank for asynchronous status levels and bus pins.
`timescale 1ns/1ps
`default_nettype none

module cff_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         nrst,
	// Levels in and out.
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	// ********************************************************
	// One pair of flops per bit; the first stage feeds only the second.
	// ********************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_reg;
			always_ff @(posedge clk) begin
				if (!nrst) begin
					meta_reg <= 1'b0;
					q[i]     <= 1'b0;
				end else begin
					meta_reg <= d[i];
					q[i]     <= meta_reg;
				end
			end
		end
	endgenerate

endmodule : cff_sync

`default_nettype wire

/* hw/cff_regs.sv */
// Fault status and event flag register bank reached over the two-wire serial bus.
// How it works
// - Both fault registers and the flag register read zero after reset.
// - Fault A bit 7 shows battery discharge current regulation.
// - Fault A bit 6 shows input bus overvoltage protection.
// - Fault A bit 5 shows battery overvoltage protection.
// - Fault A bit 4 shows input bus overcurrent protection.
// - Fault A bit 3 shows battery overcurrent protection.
// - Fault A bit 2 shows converter overcurrent protection.
// - Fault A bits 1 and 0 show second and first input overvoltage.
// - Fault B bit 7 shows system rail short circuit protection.
// - Fault B bit 6 shows system rail overvoltage protection.
// - Fault B bit 5 shows reverse output overvoltage.
// - Fault B bit 4 shows reverse output undervoltage.
// - Fault B bit 2 shows thermal shutdown; bits 3, 1, 0 read zero.
// - Flag bit 7 latches on rising input or reverse current regulation.
// - Flag bit 6 latches on rising input or reverse voltage regulation.
// - Flag bit 5 latches on rising host watchdog expiry.
// - Flag bit 4 latches on rising weak source detection.
// - Flag bit 3 latches on any change of power good.
// - Flag bit 2 latches on any change of second input presence.
// - Flag bit 1 latches on any change of first input presence.
// - Flag bit 0 latches on any change of input bus presence.
`timescale 1ns/1ps
`default_nettype none

module cff_regs
	import cff_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic nrst,
	// Serial bus pins, open drain.
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic sda_o,
	output var  logic sda_oe,
	// Protection status levels, first fault group.
	input  wire logic discharge_current_limit_active,
	input  wire logic input_bus_overvoltage,
	input  wire logic battery_overvoltage,
	input  wire logic input_bus_overcurrent,
	input  wire logic battery_overcurrent,
	input  wire logic converter_overcurrent,
	input  wire logic second_input_overvoltage,
	input  wire logic first_input_overvoltage,
	// Protection status levels, second fault group.
	input  wire logic system_rail_short,
	input  wire logic system_rail_overvoltage,
	input  wire logic reverse_output_overvoltage,
	input  wire logic reverse_output_undervoltage,
	input  wire logic die_overtemp_shutdown,
	// Event sources for the flag register.
	input  wire logic input_current_regulating,
	input  wire logic input_voltage_regulating,
	input  wire logic host_watchdog_expired,
	input  wire logic weak_source_detected,
	input  wire logic power_good_state,
	input  wire logic second_input_present,
	input  wire logic first_input_present,
	input  wire logic input_bus_present
);

	// ********************************************************
	// Declarations.
	// ********************************************************
	logic [CFF_SYNC_W-1:0] raw;
	logic [CFF_SYNC_W-1:0] syn;
	logic [7:0]            src_prev_reg;
	logic [7:0]            src_now;
	logic [7:0]            events;
	logic [7:0]            fault_status_a_reg;
	logic [7:0]            fault_status_b_reg;
	logic [7:0]            event_flags_a_reg;
	logic [7:0]            event_flags_a_next;
	logic                  flags_read;
	logic                  scl_prev_reg;
	logic                  sda_prev_reg;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  bus_start;
	logic                  bus_stop;
	cff_state_t            state_reg;
	logic [3:0]            bit_cnt_reg;
	logic [7:0]            shift_reg;
	logic [7:0]            ptr_reg;
	logic                  rw_reg;
	logic                  nack_reg;
	logic [7:0]            load_byte;

	// Register read decode; unmapped offsets read as zero.
	function automatic logic [7:0] read_mux(input logic [7:0] addr,
		input logic [7:0] fa, input logic [7:0] fb, input logic [7:0] fl);
		logic [7:0] v;
		v = CFF_UNMAPPED_VAL;
		if (addr == CFF_ADDR_FAULT_A) begin
			v = fa;
		end else if (addr == CFF_ADDR_FAULT_B) begin
			v = fb;
		end else if (addr == CFF_ADDR_FLAGS_A) begin
			v = fl;
		end
		return v;
	endfunction : read_mux

	// ********************************************************
	// Synchronisers for every asynchronous input.
	// ********************************************************
	// All status levels come from analog comparators and the bus pins from outside.
	assign raw = {sda_i, scl_i,
		input_current_regulating, input_voltage_regulating,
		host_watchdog_expired, weak_source_detected,
		power_good_state, second_input_present,
		first_input_present, input_bus_present,
		system_rail_short, system_rail_overvoltage,
		reverse_output_overvoltage, reverse_output_undervoltage,
		die_overtemp_shutdown,
		discharge_current_limit_active, input_bus_overvoltage,
		battery_overvoltage, input_bus_overcurrent,
		battery_overcurrent, converter_overcurrent,
		second_input_overvoltage, first_input_overvoltage};

	cff_sync #(
		.W (CFF_SYNC_W)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    (raw),
		.q    (syn)
	);

	// ********************************************************
	// Fault status registers.
	// ********************************************************
	// Fault bits follow the live protection levels, one clock behind the synchroniser.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_status_a_reg <= CFF_RESET_VALUE;
		end else begin
			fault_status_a_reg <= syn[CFF_SYNC_FA_LSB +: 8];
		end
	end

	// Reserved bits of the second group are held at zero.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_status_b_reg <= CFF_RESET_VALUE;
		end else begin
			fault_status_b_reg                   <= CFF_RESET_VALUE;
			fault_status_b_reg[CFF_FB_SYS_SHORT] <= syn[CFF_SYNC_FB_LSB + 4];
			fault_status_b_reg[CFF_FB_SYS_OVP]   <= syn[CFF_SYNC_FB_LSB + 3];
			fault_status_b_reg[CFF_FB_REV_OVP]   <= syn[CFF_SYNC_FB_LSB + 2];
			fault_status_b_reg[CFF_FB_REV_UVP]   <= syn[CFF_SYNC_FB_LSB + 1];
			fault_status_b_reg[CFF_FB_OVERTEMP]  <= syn[CFF_SYNC_FB_LSB + 0];
		end
	end

	// ********************************************************
	// Event detection and flag latching.
	// ********************************************************
	assign src_now = syn[CFF_SYNC_FL_LSB +: 8];

	// Previous source levels, compared only after the second sync stage.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			src_prev_reg <= 8'h00;
		end else begin
			src_prev_reg <= src_now;
		end
	end

	// Upper four flags take rising edges, lower four take either edge.
	always_comb begin
		events = src_now ^ src_prev_reg;
		events[7:CFF_FL_RISE_LOW] = src_now[7:CFF_FL_RISE_LOW]
			& ~src_prev_reg[7:CFF_FL_RISE_LOW];
	end

	// A new event in the cycle of the read still sets, so it is never lost.
	always_comb begin
		event_flags_a_next = event_flags_a_reg;
		if (flags_read) begin
			event_flags_a_next = CFF_RESET_VALUE;
		end
		event_flags_a_next = event_flags_a_next | events;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			event_flags_a_reg <= CFF_RESET_VALUE;
		end else begin
			event_flags_a_reg <= event_flags_a_next;
		end
	end

	// ********************************************************
	// Bus condition detection.
	// ********************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= syn[CFF_SYNC_SCL];
			sda_prev_reg <= syn[CFF_SYNC_SDA];
		end
	end

	assign scl_rise  = syn[CFF_SYNC_SCL] & ~scl_prev_reg;
	assign scl_fall  = ~syn[CFF_SYNC_SCL] & scl_prev_reg;
	assign bus_start = syn[CFF_SYNC_SCL] & scl_prev_reg & sda_prev_reg & ~syn[CFF_SYNC_SDA];
	assign bus_stop  = syn[CFF_SYNC_SCL] & scl_prev_reg & ~sda_prev_reg & syn[CFF_SYNC_SDA];

	// The flags are cleared at the moment their byte is loaded for sending.
	assign flags_read = scl_fall & (ptr_reg == CFF_ADDR_FLAGS_A)
		& ((state_reg == CFF_ST_ADDR_ACK && rw_reg)
		|| (state_reg == CFF_ST_TX_ACK && !nack_reg));

	// Byte at the pointer, named once so its top bit can be driven on load.
	assign load_byte = read_mux(ptr_reg, fault_status_a_reg, fault_status_b_reg, event_flags_a_reg);

	// ********************************************************
	// Serial target state machine.
	// ********************************************************
	// Bits are sampled on SCL rising and the data line changes only after SCL falls.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg   <= CFF_ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			ptr_reg     <= 8'h00;
			rw_reg      <= 1'b0;
			nack_reg    <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (bus_start) begin
			state_reg   <= CFF_ST_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe      <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= CFF_ST_IDLE;
			sda_oe    <= 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				CFF_ST_ADDR, CFF_ST_PTR, CFF_ST_WDATA: begin
					shift_reg   <= {shift_reg[6:0], syn[CFF_SYNC_SDA]};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				CFF_ST_TX: begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				CFF_ST_TX_ACK: begin
					nack_reg <= syn[CFF_SYNC_SDA];
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				CFF_ST_ADDR: begin
					if (bit_cnt_reg == CFF_BITS_PER_BYTE) begin
						if (shift_reg[7:1] == CFF_DEV_ADDR) begin
							rw_reg    <= shift_reg[0];
							sda_oe    <= 1'b1;
							state_reg <= CFF_ST_ADDR_ACK;
						end else begin
							state_reg <= CFF_ST_IDLE;
						end
					end
				end
				CFF_ST_ADDR_ACK: begin
					bit_cnt_reg <= 4'h0;
					if (rw_reg) begin
						// Read starts at the current pointer and then steps on.
						shift_reg <= load_byte;
						sda_oe    <= ~load_byte[7];
						ptr_reg   <= ptr_reg + 8'h01;
						state_reg <= CFF_ST_TX;
					end else begin
						sda_oe    <= 1'b0;
						state_reg <= CFF_ST_PTR;
					end
				end
				CFF_ST_PTR, CFF_ST_WDATA: begin
					if (bit_cnt_reg == CFF_BITS_PER_BYTE) begin
						// Data bytes are acknowledged but all registers are read only.
						if (state_reg == CFF_ST_PTR) begin
							ptr_reg <= shift_reg;
						end
						sda_oe    <= 1'b1;
						state_reg <= CFF_ST_PTR_ACK;
					end
				end
				CFF_ST_PTR_ACK: begin
					bit_cnt_reg <= 4'h0;
					sda_oe      <= 1'b0;
					state_reg   <= CFF_ST_WDATA;
				end
				CFF_ST_TX: begin
					if (bit_cnt_reg == CFF_BITS_PER_BYTE) begin
						sda_oe    <= 1'b0;
						state_reg <= CFF_ST_TX_ACK;
					end else begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						sda_oe    <= ~shift_reg[6];
					end
				end
				CFF_ST_TX_ACK: begin
					bit_cnt_reg <= 4'h0;
					if (!nack_reg) begin
						shift_reg <= load_byte;
						sda_oe    <= ~load_byte[7];
						ptr_reg   <= ptr_reg + 8'h01;
						state_reg <= CFF_ST_TX;
					end else begin
						// A host not acknowledging ends the read; wait for stop or start.
						state_reg <= CFF_ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ********************************************************
	// Open-drain data pin.
	// ********************************************************
	// The pin is only ever pulled low, so its driven level is a constant zero.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

endmodule : cff_regs

`default_nettype wire

/* bench/cff_regs_monitor.sv */
// Checker for the serial data pin of the fault and flag bank.
`timescale 1ns/1ps
`default_nettype none

module cff_regs_monitor (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Serial pins.
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	// ****
	// Cycles since the clock pin went low; saturates so long waits stay cheap.
	// ****
	logic [3:0] low_cnt_reg;

	// Counts from the first sampled low clock level.
	always_ff @(posedge clk) begin
		if (!nrst || scl_i) begin
			low_cnt_reg <= 4'h0;
		end else if (low_cnt_reg != 4'hf) begin
			low_cnt_reg <= low_cnt_reg + 4'h1;
		end
	end

	// The pin stays released during and right after reset.
	chk_reset_idle_pin: assert property (@(posedge clk) !nrst |=> !sda_oe)
		else $error("data pin driven after reset edge");
	chk_release_after_reset: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> !sda_oe[*8]) else $error("data pin driven soon after reset");
	chk_drive_only_low: assert property (@(posedge clk) disable iff (!nrst)
		sda_oe |-> !sda_o) else $error("data pin driven high");
	// Answers change only a few cycles after the clock pin falls.
	chk_rise_after_fall: assert property (@(posedge clk) disable iff (!nrst)
		$rose(sda_oe) |-> low_cnt_reg inside {[4'h2:4'h7]})
		else $error("drive began outside the low phase window");
	chk_fall_after_fall: assert property (@(posedge clk) disable iff (!nrst)
		$fell(sda_oe) |-> low_cnt_reg inside {[4'h2:4'h7]})
		else $error("drive ended outside the low phase window");
	chk_bit_held: assert property (@(posedge clk) disable iff (!nrst)
		$rose(sda_oe) |=> sda_oe[*8]) else $error("driven bit not held");
	chk_stable_clock_high: assert property (@(posedge clk) disable iff (!nrst)
		scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("pin changed while clock high");
	chk_stop_quiet: assert property (@(posedge clk) disable iff (!nrst)
		scl_i && $rose(sda_i) |=> !sda_oe[*3]) else $error("pin driven after stop");

	// Main scenarios reached.
	cov_answer: cover property (@(posedge clk) disable iff (!nrst) $rose(sda_oe));
	cov_release: cover property (@(posedge clk) $rose(nrst));
	cov_stop: cover property (@(posedge clk) disable iff (!nrst) scl_i && $rose(sda_i));
endmodule : cff_regs_monitor

bind cff_regs cff_regs_monitor u_mon (
	.clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

`default_nettype wire

/* bench/cff_host.sv */
// Serial bus host model that reads and writes the bank.
`timescale 1ns/1ps
`default_nettype none

module cff_host (
	// Clock.
	input  wire logic clk,
	// Bus pins; sda high means released.
	output var  logic scl,
	output var  logic sda,
	input  wire logic sda_in
);
	// Both pins idle released.
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Ten cycles per phase keeps both clock phases at the allowed minimum or above.
	task automatic half();
		repeat (10) @(posedge clk);
	endtask : half

	// Start or repeated start.
	task automatic start();
		half();
		sda <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda <= 1'b0;
		half();
		scl <= 1'b0;
	endtask : start

	// Data moves two cycles after the clock fall, never with it.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			repeat (2) @(posedge clk);
			sda <= tx[i];
			half();
			scl <= 1'b1;
			half();
			rx[i] = sda_in;
			scl <= 1'b0;
		end
	endtask : xfer

	task automatic stop();
		repeat (2) @(posedge clk);
		sda <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda <= 1'b1;
		half();
	endtask : stop
endmodule : cff_host

`default_nettype wire

/* bench/tb_charger_fault_flag_regs.sv */
// Self-checking bench for the fault and flag register bank.
`timescale 1ns/1ps
`default_nettype none

module tb_charger_fault_flag_regs
	import cff_pkg::*;
	();
	logic       clk     = 1'b0;
	logic       nrst    = 1'b0;
	logic [7:0] fa      = 8'h00;
	logic [4:0] fb      = 5'h00;
	logic [7:0] ev      = 8'h00;
	logic [7:0] m_flags = 8'h00;
	int         num_errors  = 0;
	int         check_count = 0;
	wire logic  scl;
	wire logic  host_sda;
	wire logic  sda_o;
	wire logic  sda_oe;
	// Open-drain wire with pull-up.
	wire logic  sda_w = host_sda & ~sda_oe;

	always #5 clk = ~clk;

	cff_host u_host (.clk(clk), .scl(scl), .sda(host_sda), .sda_in(sda_w));

	cff_regs uut (
		.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.discharge_current_limit_active(fa[7]), .input_bus_overvoltage(fa[6]),
		.battery_overvoltage(fa[5]), .input_bus_overcurrent(fa[4]),
		.battery_overcurrent(fa[3]), .converter_overcurrent(fa[2]),
		.second_input_overvoltage(fa[1]), .first_input_overvoltage(fa[0]),
		.system_rail_short(fb[4]), .system_rail_overvoltage(fb[3]),
		.reverse_output_overvoltage(fb[2]), .reverse_output_undervoltage(fb[1]),
		.die_overtemp_shutdown(fb[0]), .input_current_regulating(ev[7]),
		.input_voltage_regulating(ev[6]), .host_watchdog_expired(ev[5]),
		.weak_source_detected(ev[4]), .power_good_state(ev[3]),
		.second_input_present(ev[2]), .first_input_present(ev[1]), .input_bus_present(ev[0])
	);

	// ****
	// Checking and model.
	// ****
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] model_of(input logic [7:0] a);
		case (a)
			CFF_ADDR_FAULT_A: return fa;
			CFF_ADDR_FAULT_B: return {fb[4:1], 1'b0, fb[0], 2'b00};
			CFF_ADDR_FLAGS_A: return m_flags;
			default: return CFF_UNMAPPED_VAL;
		endcase
	endfunction : model_of

	// Upper flags latch on rises, lower ones on any change; sources settle before reads.
	task automatic set_ev(input logic [7:0] v);
		logic [7:0] hi;
		hi = 8'hff << CFF_FL_RISE_LOW;
		m_flags = m_flags | (v & ~ev & hi) | ((v ^ ev) & ~hi);
		ev <= v;
		repeat (10) @(posedge clk);
	endtask : set_ev

	// Pointer write, repeated start, then n bytes with the last one refused by the host.
	task automatic rd_regs(input logic [7:0] ptr, input int n);
		logic [8:0] rx;
		logic [7:0] a;
		u_host.start();
		u_host.xfer({CFF_DEV_ADDR, 1'b0, 1'b1}, rx);
		chk({7'h00, rx[0]}, 8'h00);
		u_host.xfer({ptr, 1'b1}, rx);
		chk({7'h00, rx[0]}, 8'h00);
		u_host.start();
		u_host.xfer({CFF_DEV_ADDR, 1'b1, 1'b1}, rx);
		chk({7'h00, rx[0]}, 8'h00);
		for (int i = 0; i < n; i++) begin
			a = ptr + i[7:0];
			u_host.xfer({8'hff, i == n - 1}, rx);
			chk(rx[8:1], model_of(a));
			if (a == CFF_ADDR_FLAGS_A) m_flags = 8'h00;
		end
		u_host.stop();
	endtask : rd_regs

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// Main sequence.
	initial begin
		logic [8:0] rx;
		int         r;
		r = $urandom(32'h7716);
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		rd_regs(CFF_ADDR_FAULT_A, 3);
		$display("test reset_values done");
		for (int i = 0; i < 18; i++) begin
			{fa, fb} <= (i < 13) ? 13'h0001 << i : 13'($urandom);
			repeat (10) @(posedge clk);
			rd_regs(CFF_ADDR_FAULT_A, 2);
		end
		$display("test fault_bits done");
		for (int i = 0; i < 8; i++) begin
			set_ev(8'h01 << i);
			rd_regs(CFF_ADDR_FLAGS_A, 1);
			rd_regs(CFF_ADDR_FLAGS_A, 1);
			set_ev(8'h00);
			rd_regs(CFF_ADDR_FLAGS_A, 1);
		end
		repeat (6) begin
			set_ev(8'($urandom));
			rd_regs(CFF_ADDR_FAULT_B, 2);
		end
		$display("test event_flags done");
		set_ev(8'h0f);
		u_host.start();
		u_host.xfer({CFF_DEV_ADDR ^ 7'h01, 1'b0, 1'b1}, rx);
		chk({7'h00, rx[0]}, 8'h01);
		u_host.stop();
		u_host.start();
		u_host.xfer({CFF_DEV_ADDR, 1'b0, 1'b1}, rx);
		u_host.xfer({CFF_ADDR_FLAGS_A, 1'b1}, rx);
		u_host.xfer({8'hff, 1'b1}, rx);
		chk({7'h00, rx[0]}, 8'h00);
		u_host.stop();
		rd_regs(CFF_ADDR_FLAGS_A, 1);
		rd_regs(8'h30, 1);
		$display("test refusals done");
		set_ev(8'hff);
		nrst <= 1'b0;
		{fa, fb, ev} <= 21'h0;
		m_flags = 8'h00;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		rd_regs(CFF_ADDR_FAULT_A, 3);
		$display("test mid_reset done");
		tally_and_finish();
	end

	// A hang ends the run as a failure.
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
endmodule : tb_charger_fault_flag_regs

`default_nettype wire
